// *** design/idc_check.sv ***
// Legality check of an idle request combination
module idc_check (
    // Requested configuration
    input wire logic [15:0] cfg,
    // Verdict
    output logic clk_stop,
    output logic bus_error
);
    logic clk_i;
    logic ext_i;
    logic all_req;

    assign clk_i = cfg[idc_pkg::CLKGEN_BIT];
    assign ext_i = cfg[idc_pkg::CLKEXT_BIT];
    assign all_req = &(cfg | ~idc_pkg::CLK_REQ_MASK);
    // Stop only when both bits set
    assign clk_stop = clk_i & ext_i & all_req;
    assign bus_error = clk_i & ~all_req;
endmodule : idc_check

// *** design/idc_pkg.sv ***
// Package of constants and types for the idle domain configuration block
// Operation
// - 16-bit config register, bits 15-10 read zero
// - Both clkgen bits and all required bits set: idle stops clock
// - Both clkgen bits clear: clock keeps running
// - Clkgen idle without extended bit: bus error
// - Clkgen idle, required bit clear: bus error
// - Bit 8 gates instruction port after idle
// - Bit 7 clear keeps DMA/host port active
// - Bit 7 set disables DMA/host port
// - Writes change nothing until idle executes
package idc_pkg;
    localparam int unsigned CFG_W = 16;
    localparam int unsigned CFG_INDEX = 1;
    localparam logic [7:0] CFG_ADDR = 8'h04;
    localparam logic [7:0] ACTIVE_ADDR = 8'h08;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h0c;
    localparam logic [7:0] IRQ_CLR_ADDR = 8'h10;
    localparam logic [7:0] IRQ_EN_ADDR = 8'h14;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] CFG_WR_MASK = 16'h03ff;
    // Bits that must accompany clkgen idle: 0,1,2,5,6,7,8,9
    localparam logic [15:0] CLK_REQ_MASK = 16'h03e7;
    localparam int unsigned CPU_BIT = 0;
    localparam int unsigned MP_BIT = 1;
    localparam int unsigned ICACHE_BIT = 2;
    localparam int unsigned PERIPH_BIT = 3;
    localparam int unsigned CLKGEN_BIT = 4;
    localparam int unsigned EXTMEM_BIT = 5;
    localparam int unsigned IO_BIT = 6;
    localparam int unsigned DMA_BIT = 7;
    localparam int unsigned INSTR_FETCH_PORT_BIT = 8;
    localparam int unsigned CLKEXT_BIT = 9;
    localparam int unsigned IRQ_BUSERR_BIT = 0;
    localparam int unsigned IRQ_IDLE_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic cpu_off;
        logic mp_off;
        logic icache_off;
        logic periph_off;
        logic clkgen_off;
        logic ext_mem_off;
        logic io_port_off;
        logic dma_host_port_off;
        logic instr_port_off;
    } idc_domains_t;
endpackage : idc_pkg

// *** design/idc_top.sv ***
// Idle domain configuration register with AXI4-Lite slave and idle control
//
// Added by the designer: the AXI4-Lite interface to the registers.
module idc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // AXI4-Lite write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    // AXI4-Lite read data
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Idle instruction from the CPU, one-cycle pulse
    input wire logic idle_exec,
    // Domain controls
    output idc_pkg::idc_domains_t domains_off,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] cfg_q;
    logic [15:0] active_q;
    logic [1:0] stat_q;
    logic [1:0] en_q;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic wr_fire;
    logic clk_stop;
    logic bus_error;
    logic [1:0] clr_bits;
    logic clr_fire;
    logic [31:0] rd_word;
    logic [1:0] rd_resp;

    // One word per register: byte address bits 1:0 are ignored
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] base);
        return addr[7:2] == base[7:2];
    endfunction : addr_hit

    idc_check u_check (
        .cfg(cfg_q),
        .clk_stop(clk_stop),
        .bus_error(bus_error)
    );

    ////////////////////////////////////////////////////////////////////////
    // Write channel capture, either order
    assign s_awready = ~aw_have_q & ~bvalid_q;
    assign s_wready = ~w_have_q & ~bvalid_q;
    assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q <= idc_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            if (awaddr_q[7:2] == idc_pkg::CFG_ADDR[7:2]) begin
                bresp_q <= idc_pkg::RESP_OKAY;
            end else if (awaddr_q[7:2] == idc_pkg::IRQ_CLR_ADDR[7:2]) begin
                bresp_q <= idc_pkg::RESP_OKAY;
            end else if (awaddr_q[7:2] == idc_pkg::IRQ_EN_ADDR[7:2]) begin
                bresp_q <= idc_pkg::RESP_OKAY;
            end else begin
                bresp_q <= idc_pkg::RESP_SLVERR;
            end
        end else if (s_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_bvalid = bvalid_q;
    assign s_bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////////
    // Config register, lanes 0 and 1
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= idc_pkg::CFG_RESET;
        end else if (wr_fire && awaddr_q[7:2] == idc_pkg::CFG_ADDR[7:2]) begin
            if (wstrb_q[0]) begin
                cfg_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
                cfg_q[15:8] <= wdata_q[15:8] & idc_pkg::CFG_WR_MASK[15:8];
            end
        end
    end

    // Applied state changes only on idle; stays put if the request faults
    always_ff @(posedge clk) begin
        if (rst) begin
            active_q <= idc_pkg::CFG_RESET;
        end else if (idle_exec && !bus_error) begin
            active_q <= cfg_q;
        end
    end

    assign domains_off.instr_port_off = active_q[idc_pkg::INSTR_FETCH_PORT_BIT];
    assign domains_off.dma_host_port_off = active_q[idc_pkg::DMA_BIT];
    assign domains_off.cpu_off = active_q[idc_pkg::CPU_BIT];
    assign domains_off.mp_off = active_q[idc_pkg::MP_BIT];
    assign domains_off.icache_off = active_q[idc_pkg::ICACHE_BIT];
    assign domains_off.periph_off = active_q[idc_pkg::PERIPH_BIT];
    // Clock stops only with both bits
    assign domains_off.clkgen_off = active_q[idc_pkg::CLKGEN_BIT]
                                    & active_q[idc_pkg::CLKEXT_BIT];
    assign domains_off.ext_mem_off = active_q[idc_pkg::EXTMEM_BIT];
    assign domains_off.io_port_off = active_q[idc_pkg::IO_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear
    assign clr_fire = wr_fire && awaddr_q[7:2] == idc_pkg::IRQ_CLR_ADDR[7:2] && wstrb_q[0];
    assign clr_bits = clr_fire ? wdata_q[1:0] : 2'h0;

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q <= 2'h0;
        end else begin
            stat_q[idc_pkg::IRQ_BUSERR_BIT] <= (idle_exec & bus_error)
                | (stat_q[idc_pkg::IRQ_BUSERR_BIT] & ~clr_bits[idc_pkg::IRQ_BUSERR_BIT]);
            stat_q[idc_pkg::IRQ_IDLE_BIT] <= (idle_exec & ~bus_error)
                | (stat_q[idc_pkg::IRQ_IDLE_BIT] & ~clr_bits[idc_pkg::IRQ_IDLE_BIT]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= 2'h0;
        end else if (wr_fire && awaddr_q[7:2] == idc_pkg::IRQ_EN_ADDR[7:2] && wstrb_q[0]) begin
            en_q <= wdata_q[1:0];
        end
    end

    assign irq = |(stat_q & en_q);

    ////////////////////////////////////////////////////////////////////////
    // Read channel, one word per register, clear register reads zero
    assign s_arready = ~rvalid_q;

    // Word select; unmapped offsets answer with an error and zero data
    always_comb begin
        rd_word = 32'h00000000;
        rd_resp = idc_pkg::RESP_OKAY;
        if (addr_hit(s_araddr, idc_pkg::CFG_ADDR)) begin
            rd_word = {16'h0000, cfg_q};
        end else if (addr_hit(s_araddr, idc_pkg::ACTIVE_ADDR)) begin
            rd_word = {16'h0000, active_q};
        end else if (addr_hit(s_araddr, idc_pkg::IRQ_STAT_ADDR)) begin
            rd_word = {30'h00000000, stat_q};
        end else if (addr_hit(s_araddr, idc_pkg::IRQ_CLR_ADDR)) begin
            rd_word = 32'h00000000;
        end else if (addr_hit(s_araddr, idc_pkg::IRQ_EN_ADDR)) begin
            rd_word = {30'h00000000, en_q};
        end else begin
            rd_resp = idc_pkg::RESP_SLVERR;
        end
    end

    // Read valid, held until the master takes it
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid_q <= 1'b0;
        end else if (s_arvalid && s_arready) begin
            rvalid_q <= 1'b1;
        end else if (s_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Data captured with the address, so it stands while rvalid stands
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
            rresp_q <= idc_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end
    end

    assign s_rvalid = rvalid_q;
    assign s_rdata = rdata_q;
    assign s_rresp = rresp_q;
endmodule : idc_top

// *** verification/idc_props.sv ***
// Checker of idle configuration behaviour at the block ports
module idc_props (
    // Write side
    input wire logic clk, rst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid,
    input wire logic [7:0] s_awaddr,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    // Read side, idle and domains
    input wire logic s_arvalid, s_arready, idle_exec,
    input wire logic [7:0] s_araddr,
    input wire logic [31:0] s_rdata,
    input wire idc_pkg::idc_domains_t domains_off
);
    logic [15:0] cfg_q;
    logic legal;
    assign legal = !cfg_q[4] || (cfg_q & idc_pkg::CLK_REQ_MASK) == idc_pkg::CLK_REQ_MASK;
    // Shadow assumes address and data are offered together
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_q <= 16'h0000;
        end else if (s_awvalid && s_awready && s_wvalid && s_wready
                && s_awaddr == idc_pkg::CFG_ADDR) begin
            if (s_wstrb[0]) cfg_q[7:0] <= s_wdata[7:0];
            if (s_wstrb[1]) cfg_q[9:8] <= s_wdata[9:8];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence wr_both; s_awvalid && s_awready && s_wvalid && s_wready; endsequence
    sequence idle_ok; idle_exec && legal; endsequence
    b_resp_time_a: assert property (wr_both |-> ##2 s_bvalid)
        else $error("write response not on time");
    cfg_read_a: assert property (s_arvalid && s_arready && s_araddr == idc_pkg::CFG_ADDR
        |=> s_rdata == {16'h0000, cfg_q}) else $error("config readback wrong");
    no_idle_hold_a: assert property (!idle_exec |=> $stable(domains_off))
        else $error("domains moved without idle");
    clk_stop_a: assert property (idle_ok and cfg_q[4] |=> domains_off.clkgen_off)
        else $error("clock generator not stopped");
    clk_run_a: assert property (idle_exec && !cfg_q[4] |=> !domains_off.clkgen_off)
        else $error("clock generator stopped");
    fault_keep_a: assert property (idle_exec && !legal |=> $stable(domains_off))
        else $error("illegal idle changed domains");
    instr_fetch_port_off_a: assert property (idle_ok |=> domains_off.instr_port_off == cfg_q[8])
        else $error("instruction port wrong");
    dma_port_a: assert property (idle_ok |=> domains_off.dma_host_port_off == cfg_q[7])
        else $error("dma host port wrong");
endmodule : idc_props

// *** verification/testbench.sv ***
// Self-checking bench of the idle domain configuration block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, idle_exec, irq;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, seed;
    logic [3:0] s_wstrb;
    logic [1:0] s_bresp, s_rresp;
    idc_pkg::idc_domains_t domains_off;
    logic [15:0] cfg_m, app_m, cases[$];
    int stat_m, en_m, mismatches, num_checks, cyc;
    idc_top idc_top_i (.*);
    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // Requests held until their own ready is seen at a rising edge
    task automatic acc(input bit w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] st, input logic [1:0] er, input logic [31:0] ed);
        bit ta, tw;
        @(posedge clk);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= {w, w, w, !w, !w};
        {ta, tw} = {!w, !w};
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta || (s_awvalid && s_awready);
            tw = tw || (s_wvalid && s_wready);
            @(posedge clk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
        end
        if (!w) begin
            do @(negedge clk); while (!s_arready);
            @(posedge clk);
            s_arvalid <= 1'b0;
        end
        do @(negedge clk); while (!(w ? s_bvalid : s_rvalid));
        chk("resp", 32'(er), 32'(w ? s_bresp : s_rresp));
        if (!w) chk("rdata", ed, s_rdata);
        @(posedge clk);
        {s_bready, s_rready} <= 2'b00;
    endtask : acc
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        if (a == idc_pkg::CFG_ADDR && st[0]) cfg_m[7:0] = d[7:0];
        if (a == idc_pkg::CFG_ADDR && st[1]) cfg_m[9:8] = d[9:8];
        if (a == idc_pkg::IRQ_EN_ADDR) en_m = int'(d[1:0]);
        if (a == idc_pkg::IRQ_CLR_ADDR) stat_m &= ~int'(d[1:0]);
        acc(1'b1, a, d, st, (a == idc_pkg::CFG_ADDR || a == idc_pkg::IRQ_EN_ADDR
            || a == idc_pkg::IRQ_CLR_ADDR) ? idc_pkg::RESP_OKAY : idc_pkg::RESP_SLVERR, 0);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic c, s, e, v, z;
        {c, s, e} = {a == idc_pkg::CFG_ADDR, a == idc_pkg::IRQ_STAT_ADDR, a == idc_pkg::IRQ_EN_ADDR};
        {v, z} = {a == idc_pkg::ACTIVE_ADDR, a == idc_pkg::IRQ_CLR_ADDR};
        acc(1'b0, a, 0, 0, (c || s || e || v || z) ? idc_pkg::RESP_OKAY : idc_pkg::RESP_SLVERR,
            c ? 32'(cfg_m) : s ? 32'(stat_m) : e ? 32'(en_m) : v ? 32'(app_m) : 32'h0);
    endtask : rd
    task automatic chk_out();
        @(negedge clk);
        chk("domains", 32'({app_m[0], app_m[1], app_m[2], app_m[3], app_m[4] & app_m[9], app_m[5], app_m[6],
            app_m[7], app_m[8]}), 32'(domains_off));
        chk("irq", 32'((stat_m & en_m) != 0), 32'(irq));
    endtask : chk_out
    task automatic idle_go();
        @(posedge clk);
        idle_exec <= 1'b1;
        @(posedge clk);
        idle_exec <= 1'b0;
        // Illegal clock stop keeps the applied state
        if (cfg_m[4] && (cfg_m & idc_pkg::CLK_REQ_MASK) != idc_pkg::CLK_REQ_MASK) stat_m |= 1;
        else {app_m, stat_m} = {cfg_m, stat_m | 2};
        chk_out();
        rd(idc_pkg::IRQ_STAT_ADDR);
        rd(idc_pkg::ACTIVE_ADDR);
    endtask : idle_go
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        {rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, idle_exec} = 7'h40;
        {s_awaddr, s_araddr, s_wdata, s_wstrb, seed} = {52'h0, 32'h4686};
        {cfg_m, app_m, stat_m, en_m, mismatches, num_checks, cyc} = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(idc_pkg::CFG_ADDR);
        chk_out();
        // Random values with random lanes, nothing applied yet
        repeat (8) begin
            wr(idc_pkg::CFG_ADDR, xs(), 4'(xs()));
            rd(idc_pkg::CFG_ADDR);
            chk_out();
        end
        wr(idc_pkg::IRQ_EN_ADDR, 3, 4'h1);
        cases = {16'h0000, 16'h03f7, 16'h0010, 16'h0210, 16'h0180, 16'h0000};
        for (int b = 0; b < 10; b++) if (idc_pkg::CLK_REQ_MASK[b]) cases.push_back(16'(16'h03ff ^ (1 << b)));
        repeat (6) cases.push_back(16'(xs()));
        foreach (cases[i]) begin
            wr(idc_pkg::CFG_ADDR, 32'(cases[i]), 4'h3);
            idle_go();
            wr(idc_pkg::IRQ_CLR_ADDR, 3, 4'h1);
            chk_out();
        end
        wr(idc_pkg::IRQ_EN_ADDR, 0, 4'h1);
        wr(idc_pkg::CFG_ADDR, 32'h10, 4'h3);
        idle_go();
        wr(idc_pkg::IRQ_STAT_ADDR, 1, 4'h1);
        wr(8'h40, 32'hffff, 4'hf);
        rd(8'h3c);
        finish_test();
    end
endmodule : testbench
bind idc_top idc_props idc_props_i (.*);
